// File: hw/activity_monitor.sv
// Purpose: puts the logic arrays into standby when their inputs sit still
// Assumes: turbo_on high keeps the arrays out of standby, and wakes them on the next edge if already in standby
// Notes: any change on the bus wakes the arrays on the next edge
`default_nettype none
module activity_monitor #(
  parameter int IN_W = 73,
  parameter int IDLE_CYCLES = bank_decode_pkg::STANDBY_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control and observed bus
  input wire logic turbo_on,
  input wire logic [IN_W-1:0] in_bus,
  // Status
  output logic standby
);
  // Whole state of the monitor
  typedef struct packed {
    logic [IN_W-1:0] last_bus;
    logic [7:0] idle;
    bank_decode_pkg::standby_t mode;
  } mon_state_t;

  mon_state_t q; // Registered state
  mon_state_t next_q; // Next state
  logic changed; // Bus differs from last edge

  // Idle counting and mode
  always_comb begin
    next_q = q;
    changed = (in_bus != q.last_bus);
    next_q.last_bus = in_bus;
    case (q.mode)
      bank_decode_pkg::ARRAY_ACTIVE: begin
        if (turbo_on || changed) begin
          next_q.idle = 8'h00;
        end else if (q.idle >= 8'(IDLE_CYCLES - 1)) begin
          next_q.mode = bank_decode_pkg::ARRAY_STANDBY;
        end else begin
          next_q.idle = q.idle + 8'h01;
        end
      end
      bank_decode_pkg::ARRAY_STANDBY: begin
        // Wake on any change or when turbo returns
        if (turbo_on || changed) begin
          next_q.mode = bank_decode_pkg::ARRAY_ACTIVE;
          next_q.idle = 8'h00;
        end
      end
      default: begin
        next_q.mode = bank_decode_pkg::ARRAY_ACTIVE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign standby = (q.mode == bank_decode_pkg::ARRAY_STANDBY);
endmodule // activity_monitor
`default_nettype wire

// File: hw/and_array.sv
// Purpose: programmable AND plane producing product terms from the bus
// Assumes: fuse maps are parameters, fixed for the life of the device
// Notes: a term with its enable clear is always false
`default_nettype none
module and_array #(
  parameter int IN_W = 73,
  parameter int TERMS = 1,
  parameter logic [TERMS*IN_W-1:0] CARE = '0,
  parameter logic [TERMS*IN_W-1:0] MATCH = '0,
  parameter logic [TERMS-1:0] TERM_EN = '0
) (
  // Input bus
  input wire logic [IN_W-1:0] in_bus,
  // Product terms
  output logic [TERMS-1:0] terms
);
  // One AND gate per term over the cared-for inputs
  for (genvar t = 0; t < TERMS; t++) begin : g_term
    localparam logic [IN_W-1:0] C = CARE[t*IN_W +: IN_W];
    localparam logic [IN_W-1:0] M = MATCH[t*IN_W +: IN_W];
    assign terms[t] = TERM_EN[t] & (&(~C | ~(in_bus ^ M)));
  end
endmodule // and_array
`default_nettype wire

// File: hw/bank_decode_pkg.sv
// Purpose: shared constants and carriers for the bank register and decode
// Assumes: one clock, sys_clk at 200 MHz, synchronous active-high reset
// Notes: input bus and decode-term layout are fixed here for all files
`default_nettype none
package bank_decode_pkg;
  // Input bus shared by both logic arrays
  localparam int INBUS_W = 73;
  localparam int BUS_ADDR_LSB = 0;
  localparam int BUS_CTL_LSB = 16;
  localparam int BUS_RST_BIT = 19;
  localparam int BUS_PDN_BIT = 20;
  localparam int BUS_INCELL_LSB = 21;
  localparam int BUS_AUX_LSB = 45;
  localparam int BUS_BANK_LSB = 48;
  localparam int BUS_FB_LSB = 56;
  localparam int BUS_READY_BIT = 72;

  // Resource counts
  localparam int PRIMARY_N = 8;
  localparam int SECONDARY_N = 4;
  localparam int SECTOR_TERMS = 3;
  localparam int SRAM_TERMS = 2;
  localparam int PERIPH_N = 2;
  localparam int DEC_TERMS = 42;
  localparam int GEN_TERMS = 137;
  localparam int OUTCELL_N = 16;
  localparam int INCELL_N = 24;
  localparam int EXT_CS_N = 3;
  localparam int GEN_OUTS = 19;
  localparam int CTL_MASK_W = 5;

  // Decode-term index layout
  localparam int DT_PRIMARY = 0;
  localparam int DT_SECONDARY = 24;
  localparam int DT_SRAM = 36;
  localparam int DT_CFG = 38;
  localparam int DT_TEST = 39;
  localparam int DT_PERIPH = 40;

  // Register offsets within the configuration block
  localparam logic [7:0] OFS_BANK = 8'hE0;
  localparam logic [7:0] OFS_OUTCELL_AB = 8'h20;
  localparam logic [7:0] OFS_OUTCELL_BC = 8'h21;
  localparam logic [7:0] OFS_INCELL_A = 8'h0A;
  localparam logic [7:0] OFS_INCELL_B = 8'h0B;
  localparam logic [7:0] OFS_INCELL_C = 8'h0C;

  // Reset values
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [15:0] OUTCELL_RESET = 16'h0000;

  // Standby timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int STANDBY_IDLE_NS = 70;
  localparam int STANDBY_CYCLES =
    (STANDBY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host request on the internal bus
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } host_req_t;

  // Decode array outputs
  typedef struct packed {
    logic [PRIMARY_N-1:0] primary;
    logic [SECONDARY_N-1:0] secondary;
    logic sram;
    logic cfg;
    logic test_port;
    logic [PERIPH_N-1:0] periph;
  } decode_t;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] bank;
    logic [OUTCELL_N-1:0] out_cells;
    logic [INCELL_N-1:0] in_cells;
    decode_t sel;
    logic [EXT_CS_N-1:0] ext_cs;
    logic [7:0] rdata;
  } core_state_t;

  // Standby monitor states
  typedef enum logic {ARRAY_ACTIVE, ARRAY_STANDBY} standby_t;
endpackage
`default_nettype wire

// File: hw/bank_register_and_address_decode.sv
// Purpose: bank register, decode array and general logic array core
// Assumes: host strobes are one-cycle pulses synchronous to sys_clk
// Notes: all logic equations are fuse-map parameters, live from reset
//
// Contract
// - Eight-bit bank register, host writable and readable
// - Bank register sits at config block plus E0h
// - All bank bits feed the decode array
// - Bank bits also usable in general array
// - Both arrays share one 73-signal input bus
// - Wide mode takes address bits 19 to 4
// - Turbo off: standby after ~70ns idle inputs
// - Five mask bits block host controls
// - Eight primary selects, three terms each
// - Four secondary selects, three terms each
// - One SRAM select from two terms
// - Config, test-port and two peripheral selects
// - Three external selects use no output cell
// - General array: cells, allocators, 137 terms
// - Host loads output cells, reads all cells
// - Equations retained and active after power-up
// - Secondary sector wins over primary sector
// - SRAM, config, peripheral win over flash
`default_nettype none
module bank_register_and_address_decode #(
  // Decode array fuse map
  parameter logic [bank_decode_pkg::DEC_TERMS*73-1:0] DEC_CARE = '0,
  parameter logic [bank_decode_pkg::DEC_TERMS*73-1:0] DEC_MATCH = '0,
  parameter logic [bank_decode_pkg::DEC_TERMS-1:0] DEC_EN = '0,
  // General array fuse map
  parameter logic [bank_decode_pkg::GEN_TERMS*73-1:0] GEN_CARE = '0,
  parameter logic [bank_decode_pkg::GEN_TERMS*73-1:0] GEN_MATCH = '0,
  parameter logic [bank_decode_pkg::GEN_TERMS-1:0] GEN_EN = '0,
  // Term allocation: 16 output cells then 3 external selects
  parameter logic [bank_decode_pkg::GEN_OUTS*137-1:0] GEN_ALLOC = '0,
  // Standby idle time in cycles
  parameter int IDLE_CYCLES = bank_decode_pkg::STANDBY_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host internal bus
  input wire bank_decode_pkg::host_req_t host_req,
  input wire logic [2:0] bus_control_inputs,
  output logic [7:0] host_rdata,
  // Mode and power control
  input wire logic wide_addr_mode,
  input wire logic turbo_on,
  input wire logic [bank_decode_pkg::CTL_MASK_W-1:0] ctl_block_mask,
  input wire logic powerdown_input,
  // Pins feeding the input cells and port D
  input wire logic [bank_decode_pkg::INCELL_N-1:0] port_inputs,
  input wire logic [2:0] aux_inputs,
  input wire logic secondary_ready,
  // Decode outputs
  output bank_decode_pkg::decode_t selects,
  // General array outputs, bank bits and standby
  output logic [bank_decode_pkg::OUTCELL_N-1:0] output_cell,
  output logic [bank_decode_pkg::EXT_CS_N-1:0] external_chip_selects,
  output logic [7:0] bank_bits,
  output logic array_standby
);
  localparam int W = bank_decode_pkg::INBUS_W;

  bank_decode_pkg::core_state_t q; // Registered state
  bank_decode_pkg::core_state_t next_q; // Next state
  logic [W-1:0] in_bus; // Shared array input bus
  logic [15:0] arr_addr; // Address seen by the arrays
  logic [2:0] ctl_gated; // Controls after blocking
  logic [bank_decode_pkg::DEC_TERMS-1:0] dec_terms; // Decode terms
  logic [bank_decode_pkg::GEN_TERMS-1:0] gen_terms; // General terms
  logic [bank_decode_pkg::GEN_OUTS-1:0] gen_sums; // Allocated sums
  bank_decode_pkg::decode_t raw_sel; // Selects before priority
  bank_decode_pkg::decode_t live_sel; // Selects after priority
  logic high_any; // SRAM, config or peripheral hit
  logic sec_any; // Any secondary sector hit
  logic standby; // Arrays idle
  logic cfg_wr; // Host write into config block
  logic cfg_rd; // Host read from config block
  logic [7:0] ofs; // Offset within config block

  assign arr_addr = wide_addr_mode ? host_req.addr[19:4]
                                   : host_req.addr[15:0];

  // block unused host controls
  // Mask bits 2:0 line up with the three control inputs
  assign ctl_gated = bus_control_inputs & ~ctl_block_mask[2:0];

  // Shared input bus assembly
  always_comb begin
    in_bus = '0;
    in_bus[bank_decode_pkg::BUS_ADDR_LSB +: 16] = arr_addr;
    in_bus[bank_decode_pkg::BUS_CTL_LSB +: 3] = ctl_gated;
    // Mask bits 3 and 4 also quiet reset and power-down
    in_bus[bank_decode_pkg::BUS_RST_BIT] = srst & ~ctl_block_mask[3];
    in_bus[bank_decode_pkg::BUS_PDN_BIT] =
      powerdown_input & ~ctl_block_mask[4];
    // Input cells, as registered from the port pins
    in_bus[bank_decode_pkg::BUS_INCELL_LSB +: 24] = q.in_cells;
    // Auxiliary port inputs go straight in
    in_bus[bank_decode_pkg::BUS_AUX_LSB +: 3] = aux_inputs;
    in_bus[bank_decode_pkg::BUS_BANK_LSB +: 8] = q.bank;
    // Output cell feedback closes counters and state machines
    in_bus[bank_decode_pkg::BUS_FB_LSB +: 16] = q.out_cells;
    // Secondary flash ready flag
    in_bus[bank_decode_pkg::BUS_READY_BIT] = secondary_ready;
  end

  // decode equations held as fuse map
  // Parameters, not registers: live from the first edge, no load step
  and_array #(
    .IN_W(W),
    .TERMS(bank_decode_pkg::DEC_TERMS),
    .CARE(DEC_CARE),
    .MATCH(DEC_MATCH),
    .TERM_EN(DEC_EN)
  ) u_decode_logic_array (
    .in_bus(in_bus),
    .terms(dec_terms)
  );

  // general array sees bank bits too
  and_array #(
    .IN_W(W),
    .TERMS(bank_decode_pkg::GEN_TERMS),
    .CARE(GEN_CARE),
    .MATCH(GEN_MATCH),
    .TERM_EN(GEN_EN)
  ) u_general_logic_array (
    .in_bus(in_bus),
    .terms(gen_terms)
  );

  // product term allocator per output
  // A term may feed several outputs; the masks are not exclusive
  for (genvar o = 0; o < bank_decode_pkg::GEN_OUTS; o++) begin : g_alloc
    localparam logic [136:0] A = GEN_ALLOC[o*137 +: 137];
    assign gen_sums[o] = |(gen_terms & A);
  end

  // Sum the decode terms into raw selects
  // Unused terms have their enable clear, so their select stays low
  always_comb begin
    raw_sel = '0;
    for (int i = 0; i < bank_decode_pkg::PRIMARY_N; i++) begin
      raw_sel.primary[i] =
        |dec_terms[bank_decode_pkg::DT_PRIMARY + 3*i +: 3];
    end
    for (int j = 0; j < bank_decode_pkg::SECONDARY_N; j++) begin
      raw_sel.secondary[j] =
        |dec_terms[bank_decode_pkg::DT_SECONDARY + 3*j +: 3];
    end
    raw_sel.sram = |dec_terms[bank_decode_pkg::DT_SRAM +: 2];
    raw_sel.cfg = dec_terms[bank_decode_pkg::DT_CFG];
    raw_sel.test_port = dec_terms[bank_decode_pkg::DT_TEST];
    raw_sel.periph = dec_terms[bank_decode_pkg::DT_PERIPH +: 2];
  end

  // Memory priority resolution
  // Fuse maps may legally overlap spaces; this ranks level one over secondary
  // over primary, but two selects within one level can still drive the bus at once
  always_comb begin
    live_sel = raw_sel;
    high_any = raw_sel.sram | raw_sel.cfg | (|raw_sel.periph);
    sec_any = |raw_sel.secondary;
    // SRAM and I/O spaces override flash
    if (high_any) begin
      // Level one hides both flash arrays
      live_sel.secondary = '0;
      live_sel.primary = '0;
    end
    if (sec_any) begin
      // Overlap hides the primary sector
      live_sel.primary = '0;
    end
  end

  // Standby watcher on the shared bus
  activity_monitor #(
    .IN_W(W),
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_activity_monitor (
    .sys_clk(sys_clk),
    .srst(srst),
    .turbo_on(turbo_on),
    .in_bus(in_bus),
    .standby(standby)
  );

  // host access qualified by config select
  assign ofs = host_req.addr[7:0];
  assign cfg_wr = host_req.wr & raw_sel.cfg;
  assign cfg_rd = host_req.rd & raw_sel.cfg;

  // Next state of the core
  // Every field starts from its held value and the branches below only
  // override what this edge changes, so no field is left unassigned
  always_comb begin
    next_q = q;
    // Input cells in pass-through, sampled each edge
    // No latch mode: the port pins are already synchronous to sys_clk
    next_q.in_cells = port_inputs;
    // output cells take allocated sums
    // Each cell is a plain D flop on the allocator output of its index
    next_q.out_cells = gen_sums[15:0];
    // host load beats internal logic
    // Low group of eight output cells
    if (cfg_wr && ofs == bank_decode_pkg::OFS_OUTCELL_AB) begin
      next_q.out_cells[7:0] = host_req.wdata;
    end
    // High group of eight output cells
    if (cfg_wr && ofs == bank_decode_pkg::OFS_OUTCELL_BC) begin
      next_q.out_cells[15:8] = host_req.wdata;
    end
    // host writes bank register
    // The new bank reaches both arrays one edge after the strobe
    if (cfg_wr && ofs == bank_decode_pkg::OFS_BANK) begin
      next_q.bank = host_req.wdata;
    end
    // Selects hold while arrays are in standby
    // Holding rather than clearing keeps an idle access selected
    if (!standby) begin
      next_q.sel = live_sel;
      next_q.ext_cs = gen_sums[18:16];
    end
    // Read mux; unmapped offsets read zero
    // Data holds between reads, so a slow host may sample it late
    if (cfg_rd) begin
      case (ofs)
        bank_decode_pkg::OFS_BANK: begin
          next_q.rdata = q.bank;
        end
        bank_decode_pkg::OFS_OUTCELL_AB: begin
          next_q.rdata = q.out_cells[7:0];
        end
        // High output cells
        bank_decode_pkg::OFS_OUTCELL_BC: begin
          next_q.rdata = q.out_cells[15:8];
        end
        // Input cells 7:0
        bank_decode_pkg::OFS_INCELL_A: begin
          next_q.rdata = q.in_cells[7:0];
        end
        // Input cells 15:8
        bank_decode_pkg::OFS_INCELL_B: begin
          next_q.rdata = q.in_cells[15:8];
        end
        // Input cells 23:16
        bank_decode_pkg::OFS_INCELL_C: begin
          next_q.rdata = q.in_cells[23:16];
        end
        // Unmapped offset
        default: begin
          next_q.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register
  // Synchronous reset; the reset branch loads constants only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q.bank <= bank_decode_pkg::BANK_RESET;
      // Output cells cleared, so feedback starts quiet
      q.out_cells <= bank_decode_pkg::OUTCELL_RESET;
      // Input cells reload on the first edge after release
      q.in_cells <= '0;
      // No memory selected while in reset
      q.sel <= '0;
      // External selects inactive
      q.ext_cs <= '0;
      // Read data idles at zero
      q.rdata <= 8'h00;
    end else begin
      // Whole state copied each edge
      q <= next_q;
    end
  end

  // Outputs straight from flip-flops
  // Standby comes from the monitor's mode flop with no gate between
  assign host_rdata = q.rdata;
  assign selects = q.sel;
  assign output_cell = q.out_cells;
  assign external_chip_selects = q.ext_cs;
  assign bank_bits = q.bank;
  assign array_standby = standby;
endmodule // bank_register_and_address_decode
`default_nettype wire

// File: test/bank_decode_properties.sv
// Purpose: port-level checks of bank register, priority and standby
// Assumes: one clock domain, synchronous active-high reset
// Notes: host access offsets are checked, not the fuse map itself
`default_nettype none
module bank_decode_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host bus and mode
  input wire bank_decode_pkg::host_req_t host_req,
  input wire logic turbo_on,
  input wire logic [7:0] host_rdata,
  // Results
  input wire bank_decode_pkg::decode_t selects,
  input wire logic [15:0] output_cell,
  input wire logic [7:0] bank_bits,
  input wire logic array_standby
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_bank_write_only: assert property ($changed(bank_bits) && !$past(srst)
    |-> $past(host_req.wr) && $past(host_req.addr[7:0]) == 8'hE0
    && bank_bits == $past(host_req.wdata)) else $error("bank moved alone");
  a_bank_read_back: assert property ($past(host_req.rd) && !$past(srst)
    && $past(host_req.addr[7:0]) == 8'hE0 && $changed(host_rdata)
    |-> host_rdata == $past(bank_bits)) else $error("bank read wrong");
  a_unmapped_read: assert property ($past(host_req.rd) && !$past(srst)
    && !($past(host_req.addr[7:0]) inside {8'hE0, 8'h20, 8'h21, 8'h0A,
    8'h0B, 8'h0C}) && $changed(host_rdata) |-> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clears: assert property ($past(srst) |-> bank_bits == 8'h00
    && output_cell == 16'h0000 && selects == '0) else $error("reset dirty");
  a_secondary_wins: assert property (|selects.secondary
    |-> selects.primary == '0) else $error("primary beside secondary");
  a_level_one_wins: assert property (selects.sram || selects.cfg
    || |selects.periph |-> selects.primary == '0
    && selects.secondary == '0) else $error("flash beside level one");
  a_standby_turbo: assert property ($rose(array_standby)
    |-> !$past(turbo_on)) else $error("standby with turbo on");
  a_turbo_wakes: assert property (array_standby && turbo_on
    |-> ##[1:2] !array_standby) else $error("turbo did not wake");
  a_standby_holds: assert property (array_standby && $past(array_standby)
    |-> $stable(selects)) else $error("selects moved in standby");

  // Main scenarios reached
  c_standby: cover property (array_standby);
  c_secondary: cover property (|selects.secondary);
  c_cfg: cover property (selects.cfg);
endmodule // bank_decode_properties
bind bank_register_and_address_decode bank_decode_properties i_props (
  .sys_clk, .srst, .host_req, .turbo_on, .host_rdata, .selects,
  .output_cell, .bank_bits, .array_standby);
`default_nettype wire

// File: test/bank_register_and_address_decode_tb.sv
// Purpose: self-checking bench against an integer model
// Assumes: fuse map below: cfg at A15, sram A13, bank bit 0 paging
// Notes: cell 0 holds itself through feedback, other cells clear
`default_nettype none
module bank_register_and_address_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 42 * 73;
  localparam int GW = 137 * 73;
  localparam logic [DW-1:0] D1 = 1;
  localparam logic [GW-1:0] G1 = 1;
  localparam logic [19*137-1:0] A1 = 1;
  // Decode fuses: primary 0, secondary 0, sram, cfg
  localparam logic [DW-1:0] DM = D1 << (38*73+15) | D1 << (24*73+48)
    | D1 << (36*73+13);
  localparam logic [DW-1:0] DC = DM | D1 << 14 | D1 << (36*73+15);
  localparam logic [41:0] DE = 42'h1 | 42'h1 << 24 | 42'h1 << 36
    | 42'h1 << 38;
  // General fuses: bank bit 0, cell 0 feedback
  localparam logic [GW-1:0] GC = G1 << 48 | G1 << (73+56);
  localparam logic [19:0] CFG = 20'h08000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic wide_addr_mode = 1'b0;
  logic turbo_on = 1'b1;
  logic [2:0] bus_control_inputs = 3'h0;
  logic [23:0] port_inputs = 24'h000000;
  bank_decode_pkg::host_req_t host_req;
  bank_decode_pkg::decode_t selects;
  logic [4:0] ctl_block_mask;
  logic [7:0] host_rdata;
  logic [15:0] output_cell;
  logic [2:0] external_chip_selects;
  logic [7:0] bank_bits;
  logic array_standby;
  int miscompares = 0;
  int n_checks = 0;
  int seed;
  int bank_m;

  // Free-running clock
  always #2.5 sys_clk = ~sys_clk;

  host_model i_host (.sys_clk, .host_req, .ctl_block_mask);

  bank_register_and_address_decode #(.DEC_CARE(DC), .DEC_MATCH(DM),
    .DEC_EN(DE), .GEN_CARE(GC), .GEN_MATCH(GC), .GEN_EN(137'h3),
    .GEN_ALLOC(A1 << 1 | A1 << (16*137)), .IDLE_CYCLES(3))
  i_bank_register_and_address_decode (.sys_clk, .srst, .host_req,
    .bus_control_inputs, .host_rdata, .wide_addr_mode, .turbo_on,
    .ctl_block_mask, .powerdown_input(1'b0), .port_inputs,
    .aux_inputs(3'h0), .secondary_ready(1'b0), .selects, .output_cell,
    .external_chip_selects, .bank_bits, .array_standby);

  // Priority model: level one, then secondary, then primary
  function automatic bank_decode_pkg::decode_t exp_sel(logic [19:0] ad,
      logic w, int b);
    logic [15:0] a;
    bank_decode_pkg::decode_t s;
    a = w ? ad[19:4] : ad[15:0];
    s = '0;
    s.cfg = a[15];
    s.sram = !a[15] && a[13];
    s.secondary[0] = b[0] && !s.cfg && !s.sram;
    s.primary[0] = !a[14] && !s.cfg && !s.sram && !s.secondary[0];
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a standby level
  task automatic wait_stby(input logic v);
    int n;
    n = 0;
    while (array_standby !== v && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(array_standby, v);
    // A wait that ran out ends the run
    if (array_standby !== v) begin
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] d;
    logic [19:0] a;
    seed = 32'hE964;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk(bank_bits, 0);
    bank_m = 0;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      i_host.acc(1'b1, CFG | 20'hE0, d);
      bank_m = d;
      chk(bank_bits, bank_m);
      i_host.acc(1'b0, CFG | 20'hE0, 8'h00);
      chk(host_rdata, bank_m);
    end
    // Mid-run reset must drop a written bank back to zero
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    bank_m = 0;
    chk(bank_bits, bank_m);
    chk(host_rdata, 0);
    // Outside the config block, then an unmapped offset
    i_host.acc(1'b1, 20'h000E0, 8'(~bank_m));
    chk(bank_bits, bank_m);
    i_host.acc(1'b0, CFG | 20'h55, 8'h00);
    chk(host_rdata, 0);
    // Output cells load, fall back or hold by feedback
    i_host.acc(1'b1, CFG | 20'h21, 8'hFF);
    chk(output_cell, 16'hFF00);
    i_host.acc(1'b1, CFG | 20'h20, 8'h01);
    i_host.acc(1'b0, CFG | 20'h20, 8'h00);
    chk(host_rdata, 1);
    chk(output_cell, 16'h0001);
    port_inputs = 24'($random(seed));
    for (int k = 0; k < 3; k++) begin
      i_host.acc(1'b0, CFG + 20'h0A + 20'(k), 8'h00);
      chk(host_rdata, (port_inputs >> (8 * k)) & 24'hFF);
    end
    // Random decode with paging and wide mode
    for (int i = 0; i < 48; i++) begin
      if (i % 4 == 0) begin
        // Bank writes need narrow mode so the config term sees A15
        wide_addr_mode = 1'b0;
        d = 8'($random(seed));
        i_host.acc(1'b1, CFG | 20'hE0, d);
        bank_m = d;
      end
      a = 20'($random(seed));
      i_host.set_addr(a);
      wide_addr_mode = 1'($random(seed));
      bus_control_inputs = 3'($random(seed));
      port_inputs = 24'($random(seed));
      repeat (2) @(negedge sys_clk);
      chk(selects, exp_sel(a, wide_addr_mode, bank_m));
      chk(external_chip_selects, bank_m & 1);
    end
    // Standby: enter, wake by address, enter, wake by turbo
    wide_addr_mode = 1'b0;
    turbo_on = 1'b0;
    wait_stby(1'b1);
    i_host.set_addr(CFG ^ 20'h04000);
    wait_stby(1'b0);
    wait_stby(1'b1);
    turbo_on = 1'b1;
    wait_stby(1'b0);
    tally_and_finish();
  end
endmodule // bank_register_and_address_decode_tb
`default_nettype wire

// File: test/host_model.sv
// Purpose: host microcontroller model on the internal bus
// Assumes: requests launched at the falling edge, held over one rise
// Notes: write data is inverted once released so stale data never matches
`default_nettype none
module host_model (
  // Clock
  input wire logic sys_clk,
  // Request towards the block
  output bank_decode_pkg::host_req_t host_req,
  output logic [4:0] ctl_block_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // equations use no bus controls, so all are blocked
  initial ctl_block_mask = 5'h1F;
  // Idle bus at time zero
  initial host_req = '0;

  // one strobe cycle, offset in the low address byte
  task automatic acc(input logic w, input logic [19:0] a,
                     input logic [7:0] d);
    @(negedge sys_clk);
    host_req.addr = a;
    host_req.wdata = d;
    host_req.wr = w;
    host_req.rd = !w;
    @(negedge sys_clk);
    host_req.wr = 1'b0;
    host_req.rd = 1'b0;
    host_req.wdata = ~d;
  endtask

  // Address alone, for the decode arrays
  task automatic set_addr(input logic [19:0] a);
    @(negedge sys_clk);
    host_req.addr = a;
  endtask
endmodule // host_model
`default_nettype wire
